// File: ext_stretch_pkg.sv
// constants, register map and state encoding for the external data bus stretch block
package ext_stretch_pkg;

  // register map (byte addresses on the wishbone port)
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STAT_OFS = 8'h04;

  // control register field positions
  localparam int PME_BIT  = 0;
  localparam int PSS_LSB  = 1;
  localparam int SSEL_LSB = 3;
  localparam int CDS_LSB  = 6;
  localparam int CMS_BIT  = 8;

  // status register field positions
  localparam int BUSY_BIT = 0;
  localparam int MISS_BIT = 1;
  localparam int PAGE_LSB = 8;

  // reset values: page mode off, no stretch, divide-by-one clocking
  localparam logic       PME_RESET  = 1'b0;
  localparam logic [1:0] PSS_RESET  = 2'b00;
  localparam logic [2:0] SSEL_RESET = 3'b000;
  localparam logic [1:0] CDS_RESET  = 2'b10;
  localparam logic       CMS_RESET  = 1'b0;

  // clock mode codes {clock_multiply_select, clock_divide_select}
  localparam logic [2:0] CM_QUAD   = 3'b100;
  localparam logic [2:0] CM_DOUBLE = 3'b000;
  localparam logic [1:0] CD_ONE    = 2'b10;
  localparam logic [1:0] CD_SLOW   = 2'b11;

  // clk_i runs at four times the oscillator; one oscillator clock is 10 ns * 4
  localparam int CLK_NS  = 10;
  localparam int OSC_NS  = 40;
  localparam int OSC_CLK = OSC_NS / CLK_NS;
  // clocks per half system clock in each clock mode
  localparam logic [11:0] HU_QUAD   = 12'h001;
  localparam logic [11:0] HU_DOUBLE = 12'((OSC_CLK / 2) / 2);
  localparam logic [11:0] HU_ONE    = 12'(OSC_CLK / 2);
  localparam logic [11:0] HU_SLOW   = 12'((OSC_CLK * 1024) / 2);

  // phase lengths in half system clocks
  localparam logic [7:0] SYS_HU     = 8'h02;
  localparam logic [7:0] STRETCH_HU = 8'h08;
  localparam logic [7:0] SMALL_SU   = SYS_HU;
  localparam logic [7:0] BIG_SU     = 8'(2 * STRETCH_HU + SYS_HU);
  localparam logic [7:0] SMALL_HD   = SYS_HU;
  localparam logic [7:0] BIG_HD     = 8'(STRETCH_HU + SYS_HU);
  // basic hit cycle per page structure select, and the four-clock cycle
  localparam logic [7:0] HIT_HU_00  = 8'h02;
  localparam logic [7:0] HIT_HU_01  = 8'h04;
  localparam logic [7:0] HIT_HU_10  = 8'h08;
  localparam logic [7:0] FOUR_HU    = 8'h08;
  localparam logic [1:0] PSS_MODE2  = 2'b11;
  localparam logic [1:0] PSS_ONE    = 2'b00;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_ALE    = 3'b001,
    ST_SETUP  = 3'b010,
    ST_STROBE = 3'b011,
    ST_HOLD   = 3'b100
  } phase_e;

endpackage

// File: hu_tick_gen.sv
// divider giving one tick per half system clock
`timescale 1ns/1ps
module hu_tick_gen
  import ext_stretch_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        clear_i,
  input  wire logic [11:0] period_i,
  output logic             tick_o
);

  logic [11:0] cnt_reg;

  // restart on clear so every access begins on a full tick
  always_ff @(posedge clk_i) begin
    if (rst_i || clear_i || tick_o) begin
      cnt_reg <= 12'h000;
    end else begin
      cnt_reg <= cnt_reg + 12'h001;
    end
  end

  assign tick_o = (cnt_reg == period_i - 12'h001);

endmodule

// File: ext_data_bus_stretch.sv
// stretch control for the external data memory bus cycle
// How it works
// R1 - each inserted stretch cycle lasts four system clocks in every page mode
// R2 - stretch select 000 adds nothing; access is the basic cycles only
// R3 - selects 1, 2, 3 add exactly 1, 2, 3 stretch cycles
// R4 - first stretch gives one clock extra setup and one extra hold
// R5 - selects 4 to 7 give two stretch cycles setup, one hold
// R6 - page miss with select 4 or more lengthens address latch pulse one stretch
// R7 - select maps to 0,1,2,3,7,8,9,10 stretch cycles
// R8 - page select 00 strobe is half a basic cycle plus stretch part
// R9 - page select 01 strobe widths 1,3,7..27 at divide by one
// R10 - page select 10 strobe widths 2,4,8..28 at divide by one
// R11 - second page structure uses the same widths as select 10
// R12 - widths scale: quad mode quarter, double half, slow mode 1024 times; quad here gets half, as its half clock rounds up to one
// R13 - page hit skips the address latch phase, so it is shorter
// R14 - select 11 data cycles equal non-page timing, four clock basic cycle
// R15 - divide setting 10 gives one system clock per oscillator clock
// R16 - page mode only while enable is set; else classic bus
// R17 - select 00, 01, 10 miss cycles are 2, 4, 8 clocks; hits half
// R18 - select 11 data accesses take four clocks, hit or miss; here select 11 always misses, an ALE phase of four clocks then four more
// R19 - stretch select is latched at access start and held throughout
// R20 - external memory must finish within the strobe; there is no wait input
//
// The register offsets and the Wishbone register port are this design's own decisions.
`timescale 1ns/1ps
module ext_data_bus_stretch
  import ext_stretch_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // wishbone slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic [31:0]      dat_o,
  output logic             ack_o,
  // external data move request from the core
  input  wire logic        xmove_req_i,
  input  wire logic        xmove_we_i,
  input  wire logic [15:0] xmove_addr_i,
  input  wire logic [7:0]  xmove_wdata_i,
  output logic             xmove_busy_o,
  output logic             xmove_done_o,
  output logic [7:0]       xmove_rdata_o,
  // external bus pins
  output logic             ale_o,
  output logic             rd_n_o,
  output logic             wr_n_o,
  output logic [7:0]       busa_o,
  output logic             busa_oe_n_o,
  input  wire logic [7:0]  busa_i,
  output logic [7:0]       busb_o,
  output logic             busb_oe_n_o,
  input  wire logic [7:0]  busb_i
);

  ////////////////////////////////////////////////////////////////////////////
  logic       page_mode_enable;
  logic [1:0] page_structure_select;
  logic [2:0] stretch_select;
  logic [1:0] clock_divide_select;
  logic       clock_multiply_select;
  logic       ack_reg;
  logic [31:0] dat_reg;
  phase_e     state_reg, state_next;
  logic [7:0] cnt_reg;
  logic [7:0] page_reg;
  logic       page_valid_reg;
  logic       miss_reg;
  logic       we_reg;
  logic [15:0] addr_reg;
  logic [7:0] wdata_reg;
  logic [2:0] ssel_reg;
  logic [7:0] hit_hu_reg;
  logic       mode2_reg;
  logic [11:0] hu_period_reg;
  logic [7:0] busa_s1, busa_s2, busb_s1, busb_s2;
  logic       tick;
  logic       start;
  logic       phase_end;
  logic       miss_now;
  logic [3:0] cyc_cnt;
  logic [3:0] eff_cnt;
  logic [7:0] ale_len, setup_len, strobe_len, hold_len;
  logic [15:0] pin_addr;
  logic [7:0] pin_wdata;
  logic       pin_we, pin_mode2;

  // stretch select to stretch cycle count
  function automatic logic [3:0] stretch_cycles(input logic [2:0] s);
    case (s)
      3'b000:  stretch_cycles = 4'h0; // R2
      3'b001:  stretch_cycles = 4'h1; // R3
      3'b010:  stretch_cycles = 4'h2;
      3'b011:  stretch_cycles = 4'h3;
      3'b100:  stretch_cycles = 4'h7; // R7
      3'b101:  stretch_cycles = 4'h8;
      3'b110:  stretch_cycles = 4'h9;
      default: stretch_cycles = 4'hA;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // wishbone: ack one cycle after the strobe, dropped the cycle after
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= cyc_i && stb_i && !ack_reg;
    end
  end

  // control register; a write mid-access only applies to the next one
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      page_mode_enable      <= PME_RESET;
      page_structure_select <= PSS_RESET;
      stretch_select        <= SSEL_RESET;
      clock_divide_select   <= CDS_RESET;
      clock_multiply_select <= CMS_RESET;
    end else if (cyc_i && stb_i && we_i && !ack_reg && adr_i == CTRL_OFS) begin
      if (sel_i[0]) begin
        page_mode_enable      <= dat_i[PME_BIT];
        page_structure_select <= dat_i[PSS_LSB +: 2];
        stretch_select        <= dat_i[SSEL_LSB +: 3];
        clock_divide_select   <= dat_i[CDS_LSB +: 2];
      end
      if (sel_i[1]) begin
        clock_multiply_select <= dat_i[CMS_BIT];
      end
    end
  end

  // read data; unmapped addresses answer zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_reg <= 32'h0000_0000;
    end else if (cyc_i && stb_i && !ack_reg) begin
      dat_reg <= 32'h0000_0000;
      if (adr_i == CTRL_OFS) begin
        dat_reg[PME_BIT]         <= page_mode_enable;
        dat_reg[PSS_LSB +: 2]    <= page_structure_select;
        dat_reg[SSEL_LSB +: 3]   <= stretch_select;
        dat_reg[CDS_LSB +: 2]    <= clock_divide_select;
        dat_reg[CMS_BIT]         <= clock_multiply_select;
      end else if (adr_i == STAT_OFS) begin
        dat_reg[BUSY_BIT]        <= state_reg != ST_IDLE;
        dat_reg[MISS_BIT]        <= miss_reg;
        dat_reg[PAGE_LSB +: 8]   <= page_reg;
      end
    end
  end

  assign ack_o = ack_reg;
  assign dat_o = dat_reg;

  ////////////////////////////////////////////////////////////////////////////
  // bus inputs come from pins: two flops before use
  always_ff @(posedge clk_i) begin
    busa_s1 <= busa_i;
    busa_s2 <= busa_s1;
    busb_s1 <= busb_i;
    busb_s2 <= busb_s1;
  end

  // page miss: classic bus, mode 2, select 00 and a new upper byte all miss
  assign miss_now = !page_mode_enable || page_structure_select == PSS_MODE2 // R16 R18
                 || page_structure_select == PSS_ONE || !page_valid_reg
                 || xmove_addr_i[15:8] != page_reg; // R13
  assign start    = state_reg == ST_IDLE && xmove_req_i;

  // the pins load at the start edge, before the latches hold this access
  assign pin_addr  = start ? xmove_addr_i : addr_reg;
  assign pin_wdata = start ? xmove_wdata_i : wdata_reg;
  assign pin_we    = start ? xmove_we_i : we_reg;
  assign pin_mode2 = start ? (!page_mode_enable || page_structure_select == PSS_MODE2)
                           : mode2_reg;

  // latch everything the access needs so mid-access writes cannot disturb it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      miss_reg <= 1'b0;
      we_reg <= 1'b0;
      addr_reg <= 16'h0000;
      wdata_reg <= 8'h00;
      ssel_reg <= 3'b000;
      hit_hu_reg <= FOUR_HU;
      mode2_reg <= 1'b0;
      hu_period_reg <= HU_ONE;
      page_reg <= 8'h00;
      page_valid_reg <= 1'b0;
    end else if (start) begin
      miss_reg <= miss_now;
      we_reg <= xmove_we_i;
      addr_reg <= xmove_addr_i;
      wdata_reg <= xmove_wdata_i;
      ssel_reg <= stretch_select; // R19
      page_reg <= xmove_addr_i[15:8];
      page_valid_reg <= 1'b1;
      mode2_reg <= !page_mode_enable || page_structure_select == PSS_MODE2;
      // basic hit cycle length: 1, 2, 4 clocks, four for select 11 or classic
      if (!page_mode_enable || page_structure_select == PSS_MODE2) begin
        hit_hu_reg <= FOUR_HU; // R14 R11
      end else if (page_structure_select == PSS_ONE) begin
        hit_hu_reg <= HIT_HU_00; // R17 R8
      end else if (page_structure_select == 2'b01) begin
        hit_hu_reg <= HIT_HU_01; // R9
      end else begin
        hit_hu_reg <= HIT_HU_10; // R10
      end
      // system clock length follows the clock mode
      if (clock_divide_select == CD_SLOW) begin
        hu_period_reg <= HU_SLOW; // R12
      end else if ({clock_multiply_select, clock_divide_select} == CM_QUAD) begin
        hu_period_reg <= HU_QUAD;
      end else if ({clock_multiply_select, clock_divide_select} == CM_DOUBLE) begin
        hu_period_reg <= HU_DOUBLE;
      end else begin
        hu_period_reg <= HU_ONE; // R15
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // phase lengths in half system clocks
  assign cyc_cnt    = stretch_cycles(ssel_reg);
  assign eff_cnt    = (cyc_cnt > 4'h3) ? cyc_cnt - 4'h3 : cyc_cnt;
  assign ale_len    = hit_hu_reg + ((ssel_reg[2]) ? STRETCH_HU : 8'h00); // R6
  assign setup_len  = (hit_hu_reg >> 1) + ((cyc_cnt == 4'h0) ? 8'h00 :
                      (ssel_reg[2] ? BIG_SU : SMALL_SU)); // R4 R5
  // each effective stretch adds four system clocks, less the setup and hold clocks
  assign strobe_len = (hit_hu_reg >> 1) + ((eff_cnt == 4'h0) ? 8'h00 :
                      8'(STRETCH_HU * eff_cnt) - 8'(2 * SYS_HU)); // R1 R3
  assign hold_len   = (cyc_cnt == 4'h0) ? 8'h00 :
                      (ssel_reg[2] ? BIG_HD : SMALL_HD); // R4 R5 R2

  hu_tick_gen u_tick (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .clear_i  (start),
    .period_i (hu_period_reg),
    .tick_o   (tick)
  );

  assign phase_end = tick && cnt_reg == 8'h01;

  // phase sequence; a hit skips the address latch phase
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE:   if (xmove_req_i) state_next = miss_now ? ST_ALE : ST_SETUP; // R13
      ST_ALE:    if (phase_end) state_next = ST_SETUP;
      ST_SETUP:  if (phase_end) state_next = ST_STROBE;
      ST_STROBE: if (phase_end) state_next = (hold_len == 8'h00) ? ST_IDLE : ST_HOLD;
      ST_HOLD:   if (phase_end) state_next = ST_IDLE;
      default:   state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // phase counter reloads on each phase entry; lengths use latched values, which
  // are valid only one clock after the start, so the first phase loads then
  always_ff @(posedge clk_i) begin
    if (rst_i || state_reg == ST_IDLE) begin
      cnt_reg <= 8'h00;
    end else if (cnt_reg == 8'h00) begin
      // a tick already due in this clock is taken off, or quad mode runs long
      cnt_reg <= ((state_reg == ST_ALE) ? ale_len : setup_len) - (tick ? 8'h01 : 8'h00);
    end else if (phase_end) begin
      case (state_next)
        ST_SETUP:  cnt_reg <= setup_len;
        ST_STROBE: cnt_reg <= strobe_len;
        ST_HOLD:   cnt_reg <= hold_len;
        default:   cnt_reg <= 8'h00;
      endcase
    end else if (tick) begin
      cnt_reg <= cnt_reg - 8'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pins registered from the next phase so they line up with state_reg
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ale_o <= 1'b0;
      rd_n_o <= 1'b1;
      wr_n_o <= 1'b1;
      busa_o <= 8'h00;
      busa_oe_n_o <= 1'b1;
      busb_o <= 8'h00;
      busb_oe_n_o <= 1'b1;
    end else begin
      ale_o <= state_next == ST_ALE;
      rd_n_o <= !(state_next == ST_STROBE && !we_reg);
      wr_n_o <= !(state_next == ST_STROBE && we_reg);
      busa_oe_n_o <= 1'b1;
      busb_oe_n_o <= 1'b1;
      if (state_next != ST_IDLE) begin
        if (pin_mode2) begin
          // address low byte on a, upper byte then data on b
          busa_o <= pin_addr[7:0];
          busa_oe_n_o <= 1'b0;
          busb_o <= (state_next == ST_ALE) ? pin_addr[15:8] : pin_wdata;
          busb_oe_n_o <= !(state_next == ST_ALE || pin_we);
        end else begin
          // page mode 1: both address bytes on b, data on a
          busb_o <= (state_next == ST_ALE) ? pin_addr[15:8] : pin_addr[7:0];
          busb_oe_n_o <= 1'b0;
          busa_o <= pin_wdata;
          busa_oe_n_o <= !(pin_we && state_next != ST_ALE);
        end
      end
    end
  end

  // read data taken at the end of the strobe; done pulses the clock after the last, as busy falls
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      xmove_rdata_o <= 8'h00;
      xmove_done_o <= 1'b0;
      xmove_busy_o <= 1'b0;
    end else begin
      xmove_done_o <= state_reg != ST_IDLE && state_next == ST_IDLE;
      xmove_busy_o <= state_next != ST_IDLE;
      if (state_reg == ST_STROBE && phase_end && !we_reg) begin
        xmove_rdata_o <= mode2_reg ? busb_s2 : busa_s2;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  logic [15:0] low_cnt;
  always_ff @(posedge clk_i) begin
    if (rst_i || (rd_n_o && wr_n_o)) begin
      low_cnt <= 16'h0000;
    end else begin
      low_cnt <= low_cnt + 16'h0001;
    end
  end

  sequence strobe_ends_s;
    !$past(rd_n_o && wr_n_o) ##0 (rd_n_o && wr_n_o);
  endsequence

  ack_single_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ack_o |=> !ack_o) else $error("ack held two cycles");
  strobe_excl_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !(!rd_n_o && !wr_n_o) && !(ale_o && !(rd_n_o && wr_n_o))) else $error("strobes overlap");
  strobe_width_a: assert property (@(posedge clk_i) disable iff (rst_i) // R8
    strobe_ends_s |-> low_cnt == 16'(strobe_len) * 16'(hu_period_reg))
    else $error("strobe width wrong");
  ssel_held_a: assert property (@(posedge clk_i) disable iff (rst_i) // R19
    (state_reg != ST_IDLE && $past(state_reg) != ST_IDLE) |-> $stable(ssel_reg))
    else $error("stretch select changed mid access");
  hit_no_ale_a: assert property (@(posedge clk_i) disable iff (rst_i) // R13
    (start && !miss_now) |=> state_reg == ST_SETUP && !ale_o) else $error("hit entered ale");
  miss_ale_a: assert property (@(posedge clk_i) disable iff (rst_i) // R17
    (start && miss_now) |=> ale_o) else $error("miss without ale");
  classic_miss_a: assert property (@(posedge clk_i) disable iff (rst_i) // R16
    (start && !page_mode_enable) |-> miss_now) else $error("classic access hit");
  zero_hold_a: assert property (@(posedge clk_i) disable iff (rst_i) // R2
    (state_reg == ST_STROBE && phase_end && ssel_reg == 3'b000) |=> state_reg == ST_IDLE)
    else $error("hold phase with no stretch");
  done_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i)
    xmove_done_o |-> !xmove_busy_o ##1 !xmove_done_o) else $error("done not a pulse");

endmodule

// File: ext_mem_model.sv
// behavioural external ram on the page mode 1 bus for the stretch bench
`timescale 1ns/1ps
module ext_mem_model (
  input  wire logic       clk_i,
  input  wire logic       ale_i,
  input  wire logic       rd_n_i,
  input  wire logic       wr_n_i,
  input  wire logic [7:0] bus_a_i,
  input  wire logic [7:0] bus_b_i,
  output logic [7:0]      drive_a_o,
  output logic [7:0]      drive_b_o
);
  logic [7:0] mem_reg [0:65535];
  logic [7:0] hi_reg;
  logic [7:0] idle_reg = 8'h3C;
  ////////////////////////////////////////////////////////////////////////////////
  // upper byte follows the latch while ale is open; low byte rides on bus b
  always @(posedge clk_i) begin
    if (ale_i) begin
      hi_reg <= bus_b_i;
    end
    if (!wr_n_i) begin
      mem_reg[{hi_reg, bus_b_i}] <= bus_a_i;
    end
    idle_reg <= ~idle_reg; // released lines toggle so stale data never looks valid
  end
  // answers at once: there is no wait input, so it must fit the strobe
  assign drive_a_o = !rd_n_i ? mem_reg[{hi_reg, bus_b_i}] : idle_reg;
  assign drive_b_o = idle_reg;
endmodule

// File: tb.sv
// self-checking bench for the external data bus stretch block
`timescale 1ns/1ps
module tb
  import ext_stretch_pkg::*;
;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, xreq = 1'b0, xwe = 1'b0;
  logic [7:0]  adr = 8'h00, xwd = 8'h00;
  logic [3:0]  sel = 4'h0;
  logic [31:0] wdat = 32'h0, dat_o;
  logic [15:0] xad = 16'h0000;
  logic        ack, busy, done, ale, rd_n, wr_n, a_oe_n, b_oe_n;
  logic [7:0]  rdata, a_out, b_out, a_drv, b_drv, a_in, b_in;
  int          n_errors = 0;
  int          num_checks = 0;
  ////////////////////////////////////////////////////////////////////////////////
  // clock and two-way pin resolution
  always #5 clk_i = ~clk_i;
  assign a_in = !a_oe_n ? a_out : a_drv;
  assign b_in = !b_oe_n ? b_out : b_drv;
  ext_data_bus_stretch dut (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
    .sel_i(sel), .dat_i(wdat), .dat_o(dat_o), .ack_o(ack), .xmove_req_i(xreq),
    .xmove_we_i(xwe), .xmove_addr_i(xad), .xmove_wdata_i(xwd), .xmove_busy_o(busy),
    .xmove_done_o(done), .xmove_rdata_o(rdata), .ale_o(ale), .rd_n_o(rd_n),
    .wr_n_o(wr_n), .busa_o(a_out), .busa_oe_n_o(a_oe_n), .busa_i(a_in),
    .busb_o(b_out), .busb_oe_n_o(b_oe_n), .busb_i(b_in)
  );
  ext_mem_model mem (
    .clk_i(clk_i), .ale_i(ale), .rd_n_i(rd_n), .wr_n_i(wr_n), .bus_a_i(a_in),
    .bus_b_i(b_in), .drive_a_o(a_drv), .drive_b_o(b_drv)
  );
  ////////////////////////////////////////////////////////////////////////////////
  // comparison and verdict
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task test_done;
    if (n_errors == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // classic wishbone single cycle; waits for ack under a bound
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= 4'hF;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (n >= 20) n_errors++;
    q = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  // mode is {clock_multiply_select, clock_divide_select}
  task ctrl(input logic en, input logic [1:0] p, input int s, input logic [2:0] m);
    logic [31:0] q;
    wb(1'b1, CTRL_OFS, (32'(m[2]) << CMS_BIT) | (32'(m[1:0]) << CDS_LSB)
       | (32'(s[2:0]) << SSEL_LSB) | (32'(p) << PSS_LSB) | 32'(en), q);
  endtask
  // one access; phases are measured in clocks and judged in half system clocks
  task acc(input logic w, input logic [15:0] ad, input logic [7:0] wd, input logic en,
           input logic [1:0] p, input int s, input int h, input bit miss,
           output logic [7:0] rd);
    int b, na, nsu, nst, nh, n;
    bit seen;
    b = (!en || p == 2'b11) ? 8 : 2 << p;
    na = 0;
    nsu = 0;
    nst = 0;
    nh = 0;
    n = 0;
    seen = 0;
    @(posedge clk_i);
    xreq <= 1'b1;
    xwe <= w;
    xad <= ad;
    xwd <= wd;
    do begin
      @(posedge clk_i);
      n++;
      if (busy === 1'b1) xreq <= 1'b0;
      if (ale === 1'b1) begin
        if (na == 0 && en && p != 2'b11) chk(b_out, ad[15:8]);
        na++;
      end else if ((w ? wr_n : rd_n) === 1'b0) begin
        nst++;
        seen = 1;
      end else if (busy === 1'b1) begin
        if (seen) nh++;
        else nsu++;
      end
    end while (done !== 1'b1 && n < 40000);
    if (n >= 40000) n_errors++;
    chk(na, miss ? (b + (s >= 4 ? 8 : 0)) * h : 0);
    chk(nsu, (b / 2 + (s == 0 ? 0 : s < 4 ? 2 : 18)) * h);
    chk(nst, (b / 2 + (s == 0 ? 0 : 8 * s - 4)) * h);
    chk(nh, (s == 0 ? 0 : s < 4 ? 2 : 10) * h);
    rd = rdata;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // reset values, read-only status, unmapped address
  task t_regs;
    logic [31:0] q;
    wb(1'b0, CTRL_OFS, 32'h0, q);
    chk(q, (32'(CMS_RESET) << CMS_BIT) | (32'(CDS_RESET) << CDS_LSB)
        | (32'(SSEL_RESET) << SSEL_LSB) | (32'(PSS_RESET) << PSS_LSB) | 32'(PME_RESET));
    wb(1'b1, CTRL_OFS, 32'h0000_01FF, q);
    wb(1'b0, CTRL_OFS, 32'h0, q);
    chk(q, 32'h0000_01FF);
    wb(1'b1, STAT_OFS, 32'hFFFF_FFFF, q);
    wb(1'b0, STAT_OFS, 32'h0, q);
    chk(q[BUSY_BIT], 1'b0);
    wb(1'b1, 8'h08, 32'hFFFF_FFFF, q);
    wb(1'b0, 8'h08, 32'h0, q);
    chk(q, 32'h0);
  endtask
  // every stretch select in every page structure and with page mode off
  task t_widths;
    logic [7:0] r;
    for (int c = 0; c < 5; c++) begin
      for (int s = 0; s < 8; s++) begin
        ctrl(c < 4, 2'(c), s, {1'b0, CD_ONE});
        acc(1'b0, {8'(c * 16 + s), 8'h00}, 8'h00, c < 4, 2'(c), s, 2, 1'b1, r);
      end
    end
  endtask
  // clock modes scale every phase; quad mode rounds a half clock up to one
  task t_clock;
    logic [2:0] m [5];
    int         hh [5];
    logic [7:0] r;
    m = '{CM_QUAD, CM_DOUBLE, {1'b0, CD_ONE}, {1'b1, CD_ONE}, {1'b0, CD_SLOW}};
    hh = '{1, 1, 2, 2, 2048};
    for (int i = 0; i < 5; i++) begin
      ctrl(1'b1, 2'b00, (i == 4) ? 0 : 2, m[i]);
      acc(1'b0, {8'(8'hA0 + i), 8'h00}, 8'h00, 1'b1, 2'b00, (i == 4) ? 0 : 2, hh[i],
          1'b1, r);
    end
  endtask
  // write then page hit read; select 00 still forces a miss
  task t_data;
    logic [7:0]  r;
    logic [31:0] q;
    ctrl(1'b1, 2'b01, 4, {1'b0, CD_ONE});
    acc(1'b1, 16'h2233, 8'hA5, 1'b1, 2'b01, 4, 2, 1'b1, r);
    acc(1'b0, 16'h2233, 8'h00, 1'b1, 2'b01, 4, 2, 1'b0, r);
    chk(r, 8'hA5);
    wb(1'b0, STAT_OFS, 32'h0, q);
    chk(q[MISS_BIT], 1'b0);
    chk(q[PAGE_LSB+:8], 8'h22);
    ctrl(1'b1, 2'b00, 4, {1'b0, CD_ONE});
    acc(1'b0, 16'h2233, 8'h00, 1'b1, 2'b00, 4, 2, 1'b1, r);
    chk(r, 8'hA5);
  endtask
  // a new stretch select written mid-access waits for the next access
  task t_latch;
    logic [7:0] r;
    ctrl(1'b1, 2'b01, 3, {1'b0, CD_ONE});
    fork
      acc(1'b0, 16'h5500, 8'h00, 1'b1, 2'b01, 3, 2, 1'b1, r);
      begin
        repeat (6) @(posedge clk_i);
        ctrl(1'b1, 2'b01, 0, {1'b0, CD_ONE});
      end
    join
    acc(1'b0, 16'h5501, 8'h00, 1'b1, 2'b01, 0, 2, 1'b0, r);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // main sequence after four reset cycles
  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs;
    t_widths;
    t_clock;
    t_data;
    t_latch;
    test_done;
  end
  // watchdog at sixty thousand cycles, well beyond the expected run of about fourteen thousand
  initial begin
    #600000;
    n_errors++;
    test_done;
  end
endmodule
